// ===== hw/stef_defs.svh
/*
  Constants of the timer event-flag block: register offsets, field
  positions, masks, reset values and bus response codes.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef STEF_DEFS_SVH
`define STEF_DEFS_SVH

// register byte offsets
`define STEF_ADDR_W       8
`define STEF_OFS_FLAG     8'h04
`define STEF_OFS_CLR      8'h08
`define STEF_OFS_EN       8'h0c

// event flag positions inside the flag, clear and enable registers
`define STEF_EVT_W        15
`define STEF_BIT_CMP0     0
`define STEF_BIT_REP      4
`define STEF_BIT_UPD      6
`define STEF_BIT_CAP0     7
`define STEF_BIT_CAP1     8
`define STEF_BIT_CH0_RISE 9
`define STEF_BIT_CH0_FALL 10
`define STEF_BIT_CH1_RISE 11
`define STEF_BIT_CH1_FALL 12
`define STEF_BIT_CNT_RST  13
`define STEF_BIT_IDLE     14

// live indicator positions in the flag register
`define STEF_BIT_BAL_CUR  16
`define STEF_BIT_BAL_IDLE 17
`define STEF_BIT_LVL0     20
`define STEF_BIT_LVL1     21

// dma enables sit this far above the matching interrupt enable
`define STEF_DMA_LSB      16

// bits 5 and 15 of each half are reserved
`define STEF_EVT_MASK     15'h7fdf
`define STEF_EN_MASK      32'h7fdf_7fdf

// reset values
`define STEF_RST_FLAG     15'h0000
`define STEF_RST_EN       32'h0000_0000

// bus
`define STEF_FULL_STRB    4'hf
`define STEF_RESP_OKAY    2'h0
`define STEF_RESP_SLVERR  2'h2

`endif

// ===== hw/stef_pkg.sv
/*
  Types of the timer event-flag block: event strobe bundle, register
  select and the whole state record of the top module.
  Assumes stef_defs.svh is on the include path.
*/
`include "stef_defs.svh"

package stef_pkg;

  // one-cycle strobes from the counter, compare and output logic
  typedef struct packed {
    logic       bal_idle;
    logic       dly_idle;
    logic       cnt_rst;
    logic       cap1;
    logic       cap0;
    logic       upd;
    logic       rep;
    logic [3:0] cmp;
  } stef_evt_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_FLAG,
    SEL_CLR,
    SEL_EN
  } stef_sel_t;

  typedef struct packed {
    logic [`STEF_EVT_W-1:0]  flags;
    logic                    bal_idle;
    logic                    bal_cur;
    logic [1:0]              lvl;
    logic [1:0]              pre_q;
    logic [31:0]             en;
    logic                    awrdy;
    logic                    aw_ok;
    logic [`STEF_ADDR_W-1:0] awaddr;
    logic                    wrdy;
    logic                    w_ok;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arrdy;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    irq;
    logic                    dma;
  } stef_state_t;

endpackage : stef_pkg

// ===== hw/stef_top.sv
/*
  Event-flag, clear and enable registers of one sub timer of the
  high resolution timer unit, with an AXI4-Lite slave, one level
  interrupt and one level DMA request.
  Assumes event strobes, pre-outputs and levels come from logic on i_clk.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
// Operation
// RL1 - software uses only full 32-bit word accesses on these registers
// RL2 - bits 21 and 20 show present output level of channels 1 and 0
// RL3 - bit 17 records driving channel at balanced idle entry
// RL4 - bit 16 shows channel currently driving in balanced mode
// RL5 - bit 14 set on delayed or balanced idle entry
// RL6 - bit 13 set on counter reset or roll-over
// RL7 - bits 10 and 12 set on pre-output falling to inactive
// RL8 - bits 9 and 11 set on pre-output rising to active
// RL9 - bits 8 and 7 set on capture 1 and capture 0 events
// RL10 - bit 6 set on each update event
// RL11 - bit 4 set on each repetition event
// RL12 - bits 3..0 set on compare events; bits 5 and 15 read zero
// RL13 - writing one to clear register bit clears that flag
// RL14 - live indicators ignore the clear register
// RL15 - dma enables at bits 30..16 gate the dma request
// RL16 - interrupt enables at bits 14..1 gate the interrupt
// RL17 - enable bit 0 gates compare 0 interrupt
// RL18 - flag, clear and enable registers read zero after reset
// RL19 - interrupt stays high while an enabled flag is set
`timescale 1ns/100ps
`default_nettype none
`include "stef_defs.svh"

module stef_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  var  stef_pkg::stef_evt_t     i_evt,
  input  wire logic [1:0]              i_pre_out,
  input  wire logic [1:0]              i_chan_level,
  input  wire logic                    i_bal_cur,
  input  wire logic                    i_s_axi_awvalid,
  output logic                         o_s_axi_awready,
  input  wire logic [`STEF_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                    i_s_axi_wvalid,
  output logic                         o_s_axi_wready,
  input  wire logic [31:0]             i_s_axi_wdata,
  input  wire logic [3:0]              i_s_axi_wstrb,
  output logic                         o_s_axi_bvalid,
  input  wire logic                    i_s_axi_bready,
  output logic [1:0]                   o_s_axi_bresp,
  input  wire logic                    i_s_axi_arvalid,
  output logic                         o_s_axi_arready,
  input  wire logic [`STEF_ADDR_W-1:0] i_s_axi_araddr,
  output logic                         o_s_axi_rvalid,
  input  wire logic                    i_s_axi_rready,
  output logic [31:0]                  o_s_axi_rdata,
  output logic [1:0]                   o_s_axi_rresp,
  output logic                         o_irq,
  output logic                         o_dma_req
);

  //////////////////////////////////////////////////////////////////////////////

  stef_pkg::stef_state_t   r_reg;
  stef_pkg::stef_state_t   r_next;
  logic [`STEF_EVT_W-1:0]  evt_set;
  logic [`STEF_EVT_W-1:0]  clr_hit;
  logic [1:0]              rise;
  logic [1:0]              fall;
  logic                    wr_go;
  logic                    wr_full;
  stef_pkg::stef_sel_t     wr_sel;
  stef_pkg::stef_sel_t     rd_sel;

  function automatic stef_pkg::stef_sel_t reg_decode(input logic [`STEF_ADDR_W-1:0] a);
    logic [`STEF_ADDR_W-1:0] w;
    w = {a[`STEF_ADDR_W-1:2], 2'h0};
    if (w == `STEF_OFS_FLAG) begin
      reg_decode = stef_pkg::SEL_FLAG;
    end else if (w == `STEF_OFS_CLR) begin
      reg_decode = stef_pkg::SEL_CLR;
    end else if (w == `STEF_OFS_EN) begin
      reg_decode = stef_pkg::SEL_EN;
    end else begin
      reg_decode = stef_pkg::SEL_NONE;
    end
  endfunction : reg_decode

  // flag register image: indicators high, sticky flags low
  function automatic logic [31:0] flag_image(input stef_pkg::stef_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    // RL12 reserved read zero
    v[`STEF_EVT_W-1:0]      = s.flags & `STEF_EVT_MASK;
    // RL4 current channel
    v[`STEF_BIT_BAL_CUR]    = s.bal_cur;
    // RL3 idle channel
    v[`STEF_BIT_BAL_IDLE]   = s.bal_idle;
    // RL2 output levels
    v[`STEF_BIT_LVL0]       = s.lvl[0];
    v[`STEF_BIT_LVL1]       = s.lvl[1];
    flag_image = v;
  endfunction : flag_image

  //////////////////////////////////////////////////////////////////////////////
  // event collection

  // RL7 falling pre-output
  assign fall = ~i_pre_out & r_reg.pre_q;
  // RL8 rising pre-output
  assign rise = i_pre_out & ~r_reg.pre_q;

  always_comb begin
    evt_set                       = '0;
    // RL12 compare strobes
    evt_set[`STEF_BIT_CMP0+3:`STEF_BIT_CMP0] = i_evt.cmp;
    // RL11 repetition
    evt_set[`STEF_BIT_REP]        = i_evt.rep;
    // RL10 update
    evt_set[`STEF_BIT_UPD]        = i_evt.upd;
    // RL9 captures
    evt_set[`STEF_BIT_CAP0]       = i_evt.cap0;
    evt_set[`STEF_BIT_CAP1]       = i_evt.cap1;
    evt_set[`STEF_BIT_CH0_RISE]   = rise[0];
    evt_set[`STEF_BIT_CH0_FALL]   = fall[0];
    evt_set[`STEF_BIT_CH1_RISE]   = rise[1];
    evt_set[`STEF_BIT_CH1_FALL]   = fall[1];
    // RL6 counter reset
    evt_set[`STEF_BIT_CNT_RST]    = i_evt.cnt_rst;
    // RL5 idle entry
    evt_set[`STEF_BIT_IDLE]       = i_evt.dly_idle | i_evt.bal_idle;
  end

  assign wr_go   = r_reg.aw_ok & r_reg.w_ok & ~r_reg.bvalid;
  assign wr_full = (r_reg.wstrb == `STEF_FULL_STRB);
  assign wr_sel  = reg_decode(r_reg.awaddr);
  assign rd_sel  = reg_decode(i_s_axi_araddr);

  // RL13 one clears, zero keeps
  // RL1 partial strobes change nothing
  assign clr_hit = (wr_go && wr_full && wr_sel == stef_pkg::SEL_CLR) ?
                   (r_reg.wdata[`STEF_EVT_W-1:0] & `STEF_EVT_MASK) : '0;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    if (i_ce) begin
      // RL13 a set in the clearing cycle wins
      r_next.flags = ((r_reg.flags & ~clr_hit) | evt_set) & `STEF_EVT_MASK;
      // RL14 indicators only track hardware
      // RL2 output levels
      r_next.lvl   = i_chan_level;
      // RL4 current channel
      r_next.bal_cur = i_bal_cur;
      // RL3 latch on balanced idle entry
      if (i_evt.bal_idle) begin
        r_next.bal_idle = i_bal_cur;
      end
      r_next.pre_q = i_pre_out;

      // write side
      if (r_reg.bvalid && i_s_axi_bready) begin
        r_next.bvalid = 1'b0;
      end
      if (i_s_axi_awvalid && r_reg.awrdy) begin
        r_next.aw_ok  = 1'b1;
        r_next.awaddr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && r_reg.wrdy) begin
        r_next.w_ok  = 1'b1;
        r_next.wdata = i_s_axi_wdata;
        r_next.wstrb = i_s_axi_wstrb;
      end
      if (wr_go) begin
        r_next.aw_ok  = 1'b0;
        r_next.w_ok   = 1'b0;
        r_next.bvalid = 1'b1;
        r_next.bresp  = (wr_sel == stef_pkg::SEL_NONE || !wr_full) ?
                        `STEF_RESP_SLVERR : `STEF_RESP_OKAY;
        // RL15 dma enables, RL16 interrupt enables, RL17 bit 0
        if (wr_full && wr_sel == stef_pkg::SEL_EN) begin
          r_next.en = r_reg.wdata & `STEF_EN_MASK;
        end
      end

      // read side; answer one cycle after the address is taken
      if (i_s_axi_arvalid && r_reg.arrdy) begin
        r_next.rvalid = 1'b1;
        r_next.rresp  = `STEF_RESP_OKAY;
        unique case (rd_sel)
          stef_pkg::SEL_FLAG: r_next.rdata = flag_image(r_reg);
          // clear register is write-only
          stef_pkg::SEL_CLR:  r_next.rdata = 32'h0000_0000;
          stef_pkg::SEL_EN:   r_next.rdata = r_reg.en;
          stef_pkg::SEL_NONE: begin
            r_next.rdata = 32'h0000_0000;
            r_next.rresp = `STEF_RESP_SLVERR;
          end
        endcase
      end else if (r_reg.rvalid && i_s_axi_rready) begin
        r_next.rvalid = 1'b0;
      end

      // one write and one read in flight at a time
      r_next.awrdy = ~r_next.aw_ok & ~r_next.bvalid;
      r_next.wrdy  = ~r_next.w_ok & ~r_next.bvalid;
      r_next.arrdy = ~r_next.rvalid;

      // RL19 level interrupt while an enabled flag stands
      // RL16 gated by enables
      r_next.irq = |(r_next.flags & r_next.en[`STEF_EVT_W-1:0]);
      // RL15 dma gated by enables
      r_next.dma = |(r_next.flags & r_next.en[`STEF_DMA_LSB+`STEF_EVT_W-1:`STEF_DMA_LSB]);
    end
  end

  // RL18 everything reads zero after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_s_axi_awready = r_reg.awrdy;
  assign o_s_axi_wready  = r_reg.wrdy;
  assign o_s_axi_bvalid  = r_reg.bvalid;
  assign o_s_axi_bresp   = r_reg.bresp;
  assign o_s_axi_arready = r_reg.arrdy;
  assign o_s_axi_rvalid  = r_reg.rvalid;
  assign o_s_axi_rdata   = r_reg.rdata;
  assign o_s_axi_rresp   = r_reg.rresp;
  assign o_irq           = r_reg.irq;
  assign o_dma_req       = r_reg.dma;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_level_follow: assert property (i_ce |=> r_reg.lvl == $past(i_chan_level)) // RL2
    else $error("channel level indicator did not follow");

  a_bal_capture: assert property (i_ce && i_evt.bal_idle |=> r_reg.bal_idle == $past(i_bal_cur)) // RL3
    else $error("balanced idle channel not captured");

  a_bal_current: assert property (i_ce |=> r_reg.bal_cur == $past(i_bal_cur)) // RL4
    else $error("balanced current channel wrong");

  a_idle_entry: assert property (i_ce && (i_evt.dly_idle || i_evt.bal_idle)
                                 |=> r_reg.flags[`STEF_BIT_IDLE]) // RL5
    else $error("idle entry flag not set");

  a_counter_reset: assert property (i_ce && i_evt.cnt_rst |=> r_reg.flags[`STEF_BIT_CNT_RST]) // RL6
    else $error("counter reset flag not set");

  a_fall_flag: assert property (i_ce && r_reg.pre_q[0] && !i_pre_out[0]
                                |=> r_reg.flags[`STEF_BIT_CH0_FALL]) // RL7
    else $error("channel 0 inactive flag not set");

  a_rise_flag: assert property (i_ce && !r_reg.pre_q[1] && i_pre_out[1]
                                |=> r_reg.flags[`STEF_BIT_CH1_RISE]) // RL8
    else $error("channel 1 active flag not set");

  a_capture_flag: assert property (i_ce && i_evt.cap1 |=> r_reg.flags[`STEF_BIT_CAP1]) // RL9
    else $error("capture 1 flag not set");

  a_update_flag: assert property (i_ce && i_evt.upd |=> r_reg.flags[`STEF_BIT_UPD] [*1]) // RL10
    else $error("update flag not set");

  a_repeat_flag: assert property (i_ce && i_evt.rep |=> r_reg.flags[`STEF_BIT_REP]) // RL11
    else $error("repetition flag not set");

  a_reserved_zero: assert property (r_reg.flags[5] == 1'b0 && r_reg.en[21] == 1'b0) // RL12
    else $error("reserved bit set");

  a_clear_works: assert property (i_ce |=> (r_reg.flags & $past(clr_hit & ~evt_set)) == '0) // RL13
    else $error("flag survived its clear");

  a_set_wins: assert property (i_ce && clr_hit[0] && i_evt.cmp[0] |=> r_reg.flags[0]) // RL13
    else $error("event lost during clear");

  // levels may move in any cycle, so compare with the pin, not with the old value
  a_ind_keep: assert property (i_ce && clr_hit != '0 |=> r_reg.lvl == $past(i_chan_level)
                               && r_reg.bal_cur == $past(i_bal_cur)) // RL14
    else $error("indicator disturbed by clear");

  a_dma_gate: assert property (o_dma_req |->
                               |(r_reg.flags & r_reg.en[30:16])) // RL15
    else $error("dma request without enabled flag");

  a_irq_hold: assert property (o_irq && !i_ce |=> o_irq) // RL19
    else $error("interrupt dropped while frozen");

  a_irq_match: assert property (o_irq == |(r_reg.flags & r_reg.en[14:0])) // RL16
    else $error("interrupt does not match enabled flags");

  a_cmp0_irq: assert property (i_ce && i_evt.cmp[0] && r_reg.en[0] && !(wr_go && wr_sel ==
                               stef_pkg::SEL_EN) |=> o_irq) // RL17
    else $error("compare 0 interrupt missing");

  a_reset_zero: assert property ($past(i_rst) |-> r_reg.flags == '0 && r_reg.en == '0) // RL18
    else $error("registers not zero after reset");

  a_read_latency: assert property (i_ce && i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");

  // the other channel of each edge kind and of capture, then the compare flags
  a_rise_ch0: assert property (i_ce && !r_reg.pre_q[0] && i_pre_out[0]
                               |=> r_reg.flags[`STEF_BIT_CH0_RISE]) // RL8
    else $error("channel 0 active flag not set");

  a_fall_ch1: assert property (i_ce && r_reg.pre_q[1] && !i_pre_out[1]
                               |=> r_reg.flags[`STEF_BIT_CH1_FALL]) // RL7
    else $error("channel 1 inactive flag not set");

  a_capture0_flag: assert property (i_ce && i_evt.cap0 |=> r_reg.flags[`STEF_BIT_CAP0]) // RL9
    else $error("capture 0 flag not set");

  a_compare_flags: assert property (i_ce |=> (r_reg.flags[3:0] & $past(i_evt.cmp))
                                    == $past(i_evt.cmp)) // RL12
    else $error("compare flag not set");

  // a flag may rise only on its own strobe or edge
  a_no_stray_flag: assert property (i_ce |=> (r_reg.flags & ~$past(r_reg.flags)
                                    & ~$past(evt_set)) == '0) // RL12
    else $error("flag set without an event");

  a_bal_hold: assert property (i_ce && !i_evt.bal_idle |=> $stable(r_reg.bal_idle)) // RL3
    else $error("balanced idle channel changed without entry");

  a_dma_raise: assert property (i_ce && i_evt.rep && r_reg.en[`STEF_DMA_LSB+`STEF_BIT_REP]
                                && !(wr_go && wr_sel == stef_pkg::SEL_EN) |=> o_dma_req) // RL15
    else $error("repetition dma request missing");

  a_update_irq: assert property (i_ce && i_evt.upd && r_reg.en[`STEF_BIT_UPD]
                                 && !(wr_go && wr_sel == stef_pkg::SEL_EN) |=> o_irq) // RL16
    else $error("update interrupt missing");

  // an enable write keeps the whole word except the reserved bits
  a_enable_write: assert property (wr_go && wr_full && wr_sel == stef_pkg::SEL_EN && i_ce
                                   |=> r_reg.en == ($past(r_reg.wdata) & `STEF_EN_MASK)) // RL16
    else $error("enable register not written");

  a_partial_write: assert property (i_ce && wr_go && !wr_full
                                    |=> $stable(r_reg.en) && o_s_axi_bresp == `STEF_RESP_SLVERR)
    else $error("partial write not refused");

  a_write_answer: assert property (i_ce && wr_go |=> o_s_axi_bvalid)
    else $error("write answer late");

  a_resp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready
                                  |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");

  a_rdata_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready
                                   |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");

  // with the enable low nothing may move, bus included
  a_freeze_hold: assert property (!i_ce |=> $stable(r_reg.flags) && $stable(r_reg.en)
                                  && $stable(o_s_axi_rvalid))
    else $error("state moved while frozen");

  // main scenarios
  c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
  c_read_flag: cover property (o_s_axi_rvalid && o_s_axi_rdata != 32'h0000_0000);
  c_irq: cover property ($rose(o_irq));
  c_dma: cover property ($rose(o_dma_req));
  c_frozen_irq: cover property (!i_ce && o_irq);

endmodule : stef_top
`default_nettype wire

// ===== testbench/stef_host_model.sv
/*
  bus master model standing for software on the AXI4-Lite register bus.
  assumes one clock and word-wide registers; the bench calls its tasks.
*/
`timescale 1ns/100ps
`default_nettype none
module stef_host_model (
  input  wire logic        i_clk,
  output var  logic        o_awvalid,
  output var  logic [7:0]  o_awaddr,
  output var  logic        o_wvalid,
  output var  logic [31:0] o_wdata,
  output var  logic [3:0]  o_wstrb,
  output var  logic        o_bready,
  output var  logic        o_arvalid,
  output var  logic [7:0]  o_araddr,
  output var  logic        o_rready,
  input  wire logic        i_awready,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_arready,
  input  wire logic        i_rvalid,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  initial begin
    {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_wstrb, o_bready} = '0;
    {o_arvalid, o_araddr, o_rready} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  // word-wide transfers; the write strobe comes from the caller
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] resp, output bit to);
    int n;
    n = 0;
    to = 1'b1;
    resp = 2'h3;
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr  <= a;
    o_wvalid  <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= s;
    o_bready  <= 1'b1;
    while (n < 64) begin
      @(posedge i_clk);
      n++;
      // released address and data lines show no stale value
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
      if (i_bvalid) begin
        resp = i_bresp;
        to = 1'b0;
        o_bready <= 1'b0;
        n = 64;
      end
    end
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp,
                      output bit to);
    int n;
    n = 0;
    to = 1'b1;
    d = '0;
    resp = 2'h3;
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr  <= a;
    o_rready  <= 1'b1;
    while (n < 64) begin
      @(posedge i_clk);
      n++;
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
      if (i_rvalid) begin
        d = i_rdata;
        resp = i_rresp;
        to = 1'b0;
        o_rready <= 1'b0;
        n = 64;
      end
    end
  endtask : read
endmodule : stef_host_model
`default_nettype wire

// ===== testbench/slave_timer_event_flags_test.sv
/*
  self-checking bench of the timer event-flag block.
  assumes stef_pkg, stef_top and stef_host_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module slave_timer_event_flags_test;
  logic                clk, rst, ce, bal, irq, dma;
  stef_pkg::stef_evt_t evt;
  logic [1:0]          pre, lvl, bresp, rresp;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb;
  int                  fail_count, comparisons;
  // flag position of each strobe bit, lowest strobe first
  int                  pos [11] = '{0, 1, 2, 3, 4, 6, 7, 8, 13, 14, 14};

  stef_top DUT (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_evt(evt), .i_pre_out(pre),
    .i_chan_level(lvl), .i_bal_cur(bal), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_irq(irq), .o_dma_req(dma));

  stef_host_model HOST (.i_clk(clk), .o_awvalid(awvalid), .o_awaddr(awaddr),
    .o_wvalid(wvalid), .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready),
    .o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready), .i_awready(awready),
    .i_wready(wready), .i_bvalid(bvalid), .i_bresp(bresp), .i_arready(arready),
    .i_rvalid(rvalid), .i_rdata(rdata), .i_rresp(rresp));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         to;
    HOST.write(a, d, s, r, to);
    // a hung handshake ends the run at once
    if (to) begin
      fail_count++;
      report_and_stop();
    end
    chk_resp("bresp", er, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          to;
    HOST.read(a, d, r, to);
    if (to) begin
      fail_count++;
      report_and_stop();
    end
    chk("rdata", e, d);
    chk_resp("rresp", er, r);
  endtask : rd

  task automatic pulse(input int i);
    @(posedge clk);
    evt <= 11'h1 << i;
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask : pulse

  // irq and dma are registered, so one edge is let pass first
  task automatic pins(input logic ei, input logic ed);
    @(posedge clk);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    chk("dma", {31'h0, ed}, {31'h0, dma});
  endtask : pins
  //////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_events();
    logic [31:0] b;
    for (int i = 0; i < 11; i++) begin
      b = 32'h1 << pos[i];
      pulse(i);
      rd(8'h04, b, 2'h0);
      wr(8'h08, ~b & 32'h0000_7fff, 4'hf, 2'h0);
      rd(8'h04, b, 2'h0);
      wr(8'h08, b, 4'hf, 2'h0);
      rd(8'h04, 32'h0, 2'h0);
    end
    $display("test events done");
  endtask : test_events

  task automatic test_outputs();
    @(posedge clk);
    pre <= 2'b01;
    @(posedge clk);
    pre <= 2'b00;
    @(posedge clk);
    pre <= 2'b10;
    @(posedge clk);
    pre <= 2'b00;
    lvl <= 2'b10;
    bal <= 1'b1;
    @(posedge clk);
    rd(8'h04, 32'h0021_1e00, 2'h0);
    pulse(10);
    rd(8'h04, 32'h0023_5e00, 2'h0);
    wr(8'h08, 32'hffff_ffff, 4'hf, 2'h0);
    rd(8'h04, 32'h0023_0000, 2'h0);
    lvl <= 2'b01;
    bal <= 1'b0;
    rd(8'h04, 32'h0012_0000, 2'h0);
    $display("test outputs done");
  endtask : test_outputs

  task automatic test_mask();
    wr(8'h0c, 32'hffff_ffff, 4'hf, 2'h0);
    rd(8'h0c, 32'h7fdf_7fdf, 2'h0);
    pins(1'b0, 1'b0);
    pulse(1);
    pins(1'b1, 1'b1);
    wr(8'h0c, 32'h0000_0001, 4'hf, 2'h0);
    pins(1'b0, 1'b0);
    pulse(0);
    pins(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    pins(1'b1, 1'b0);
    wr(8'h08, 32'h0000_0001, 4'hf, 2'h0);
    pins(1'b0, 1'b0);
    wr(8'h0c, 32'h0002_0000, 4'hf, 2'h0);
    pins(1'b0, 1'b1);
    wr(8'h08, 32'h0000_0002, 4'hf, 2'h0);
    pins(1'b0, 1'b0);
    $display("test mask done");
  endtask : test_mask

  task automatic test_refuse();
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'h1, 4'hf, 2'h2);
    wr(8'h0c, 32'h0000_0040, 4'h3, 2'h2);
    rd(8'h0c, 32'h0002_0000, 2'h0);
    wr(8'h04, 32'hffff_ffff, 4'hf, 2'h0);
    rd(8'h04, 32'h0012_0000, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    $display("test refuse done");
  endtask : test_refuse

  // enable low must freeze flags and the interrupt; a mid-run reset zeroes what was set
  task automatic test_freeze_reset();
    wr(8'h0c, 32'h0000_0010, 4'hf, 2'h0);
    pulse(4);
    ce <= 1'b0;
    pulse(0);
    pins(1'b1, 1'b0);
    ce <= 1'b1;
    rd(8'h04, 32'h0012_0010, 2'h0);
    @(posedge clk);
    rst <= 1'b1;
    lvl <= 2'b00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    pins(1'b0, 1'b0);
    $display("test freeze and reset done");
  endtask : test_freeze_reset
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    evt = '0;
    pre = '0;
    lvl = '0;
    bal = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_events();
    test_outputs();
    test_mask();
    test_refuse();
    test_freeze_reset();
    report_and_stop();
  end
endmodule : slave_timer_event_flags_test
`default_nettype wire
